// ### rtl/fpf_port.v
`include "fpf_regs.vh"

////////////////////////////////////////////////////////////////////
// How it works
// - during reset the select inputs pick one of three presets or programming
// - with both selects low, first four port writes load the four offsets
// - offset writes never enter the queue; normal operation follows by itself
// - offset is unsigned data bits 0 to 8, legal range 1 to 508
// - data bits 9 to 35 are ignored while offsets are programmed
// - near-empty low while stored words at or below offset, else high
// - near-full low while free locations at or below offset, else high
// - on read edge a new word loads the output register when not valid
// - with output valid, next word loads only on a selected read edge
// - written word reaches the output register on the third read-side clock edge
// - first word falls through to output register and leaves the count
// - near-full high with offset plus one free; software uses packet minus one
module fpf_port (
  input wire sys_clk,
  input wire rst,
  input wire offset_select_0,
  input wire offset_select_1,
  input wire port_a_clock,
  input wire port_a_select_n,
  input wire port_a_enable,
  input wire port_a_direction,
  input wire [`FPF_DATA_W-1:0] port_a_data_in,
  output wire [`FPF_DATA_W-1:0] port_a_data_out,
  output reg port_a_data_oe_reg,
  output wire out_valid_port_a,
  output wire in_space_port_a,
  output wire near_empty_port_a,
  output wire near_full_port_a,
  output reg prog_active_reg,
  input wire user_wr_valid,
  input wire [`FPF_DATA_W-1:0] user_wr_data,
  output wire user_wr_space,
  input wire user_rd_en,
  output wire [`FPF_DATA_W-1:0] user_rd_data,
  output wire user_rd_valid,
  output wire near_empty_port_b,
  output wire near_full_port_b
);

  reg clk_s1_reg;
  reg clk_s2_reg;
  reg clk_s3_reg;
  reg sel_n_s1_reg;
  reg sel_n_s2_reg;
  reg en_s1_reg;
  reg en_s2_reg;
  reg dir_s1_reg;
  reg dir_s2_reg;
  reg [`FPF_DATA_W-1:0] data_s1_reg;
  reg [`FPF_DATA_W-1:0] data_s2_reg;
  reg fs0_s1_reg;
  reg fs0_s2_reg;
  reg fs1_s1_reg;
  reg fs1_s2_reg;
  reg [`FPF_PROG_CNT_W-1:0] prog_cnt_reg;
  reg [`FPF_OFF_W-1:0] ne_a_off_reg;
  reg [`FPF_OFF_W-1:0] ne_b_off_reg;
  reg [`FPF_OFF_W-1:0] nf_a_off_reg;
  reg [`FPF_OFF_W-1:0] nf_b_off_reg;
  reg [`FPF_OFF_W-1:0] preset_next;
  wire [1:0] mode_sel;
  wire a_edge;
  wire a_access;
  wire a_write;
  wire a_read;
  wire [`FPF_OFF_W-1:0] off_value;
  wire fwd_space;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always @(posedge sys_clk) begin
    if (rst) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      sel_n_s1_reg <= 1'b1;
      sel_n_s2_reg <= 1'b1;
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      dir_s1_reg <= 1'b0;
      dir_s2_reg <= 1'b0;
      data_s1_reg <= {`FPF_DATA_W{1'b0}};
      data_s2_reg <= {`FPF_DATA_W{1'b0}};
    end else begin
      clk_s1_reg <= port_a_clock;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      sel_n_s1_reg <= port_a_select_n;
      sel_n_s2_reg <= sel_n_s1_reg;
      en_s1_reg <= port_a_enable;
      en_s2_reg <= en_s1_reg;
      dir_s1_reg <= port_a_direction;
      dir_s2_reg <= dir_s1_reg;
      data_s1_reg <= port_a_data_in;
      data_s2_reg <= data_s1_reg;
    end
  end

  // selects keep sampling through reset so the mode can be caught there
  always @(posedge sys_clk) begin
    fs0_s1_reg <= offset_select_0;
    fs0_s2_reg <= fs0_s1_reg;
    fs1_s1_reg <= offset_select_1;
    fs1_s2_reg <= fs1_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // port decode on the sampled rising edge of the port clock
  assign a_edge = clk_s2_reg & ~clk_s3_reg;
  assign a_access = a_edge & ~sel_n_s2_reg & en_s2_reg;
  assign a_write = a_access & dir_s2_reg;
  assign a_read = a_access & ~dir_s2_reg;
  assign off_value = data_s2_reg[`FPF_OFF_MSB:`FPF_OFF_LSB];
  assign mode_sel = {fs1_s2_reg, fs0_s2_reg};

  always @* begin
    case (mode_sel)
      `FPF_MODE_PRESET_A: preset_next = `FPF_PRESET_A;
      `FPF_MODE_PRESET_B: preset_next = `FPF_PRESET_B;
      `FPF_MODE_PRESET_C: preset_next = `FPF_PRESET_C;
      default: preset_next = `FPF_OFF_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // offset mode and programming sequence
  always @(posedge sys_clk) begin
    if (rst) begin
      prog_active_reg <= (mode_sel == `FPF_MODE_PROG);
      prog_cnt_reg <= `FPF_PROG_NE_A;
      ne_a_off_reg <= preset_next;
      ne_b_off_reg <= preset_next;
      nf_a_off_reg <= preset_next;
      nf_b_off_reg <= preset_next;
    end else if (a_write & prog_active_reg) begin
      case (prog_cnt_reg)
        `FPF_PROG_NE_A: ne_a_off_reg <= off_value;
        `FPF_PROG_NE_B: ne_b_off_reg <= off_value;
        `FPF_PROG_NF_A: nf_a_off_reg <= off_value;
        `FPF_PROG_NF_B: nf_b_off_reg <= off_value;
        default: ne_a_off_reg <= off_value;
      endcase
      prog_cnt_reg <= prog_cnt_reg + {{(`FPF_PROG_CNT_W-1){1'b0}}, 1'b1};
      if (prog_cnt_reg == `FPF_PROG_NF_B) begin
        prog_active_reg <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      port_a_data_oe_reg <= 1'b0;
    end else begin
      port_a_data_oe_reg <= ~sel_n_s2_reg & ~dir_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // forward queue: port writes in, user reads out
  fpf_queue u_forward_queue (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(a_write & ~prog_active_reg),
    .push_data(data_s2_reg),
    .pop_tick(1'b1),
    .pop_take(user_rd_en),
    .near_empty_off(ne_b_off_reg),
    .near_full_off(nf_a_off_reg),
    .head_data_reg(user_rd_data),
    .head_valid_reg(user_rd_valid),
    .has_space_reg(fwd_space),
    .near_empty_reg(near_empty_port_b),
    .near_full_reg(near_full_port_a)
  );

  // space shown as available while offsets are being taken
  assign in_space_port_a = fwd_space;

  ////////////////////////////////////////////////////////////////////
  // return queue: user writes in, port reads out on its clock edges
  fpf_queue u_return_queue (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(user_wr_valid),
    .push_data(user_wr_data),
    .pop_tick(a_edge),
    .pop_take(a_read),
    .near_empty_off(ne_a_off_reg),
    .near_full_off(nf_b_off_reg),
    .head_data_reg(port_a_data_out),
    .head_valid_reg(out_valid_port_a),
    .has_space_reg(user_wr_space),
    .near_empty_reg(near_empty_port_a),
    .near_full_reg(near_full_port_b)
  );

endmodule

// ### rtl/fpf_queue.v
`include "fpf_regs.vh"

module fpf_queue (
  input wire sys_clk,
  input wire rst,
  input wire push,
  input wire [`FPF_DATA_W-1:0] push_data,
  input wire pop_tick,
  input wire pop_take,
  input wire [`FPF_OFF_W-1:0] near_empty_off,
  input wire [`FPF_OFF_W-1:0] near_full_off,
  output reg [`FPF_DATA_W-1:0] head_data_reg,
  output reg head_valid_reg,
  output reg has_space_reg,
  output reg near_empty_reg,
  output reg near_full_reg
);

  reg [`FPF_DATA_W-1:0] mem [0:`FPF_DEPTH-1];
  reg [`FPF_PTR_W-1:0] wr_ptr_reg;
  reg [`FPF_PTR_W-1:0] rd_ptr_reg;
  reg [`FPF_PTR_W-1:0] seen1_reg;
  reg [`FPF_PTR_W-1:0] seen2_reg;
  wire [`FPF_PTR_W-1:0] stored_next;
  wire [`FPF_PTR_W-1:0] free_next;
  wire avail;
  wire load;
  wire do_push;

  ////////////////////////////////////////////////////////////////////
  // write pointer seen by the read side only after two read edges
  assign avail = (seen2_reg != rd_ptr_reg);
  assign load = pop_tick & avail & (~head_valid_reg | pop_take);
  assign do_push = push & has_space_reg;
  assign stored_next = (wr_ptr_reg + {{(`FPF_PTR_W-1){1'b0}}, do_push})
                     - (rd_ptr_reg + {{(`FPF_PTR_W-1){1'b0}}, load});
  assign free_next = `FPF_DEPTH - stored_next;

  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg[`FPF_ADDR_W-1:0]] <= push_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_reg <= {`FPF_PTR_W{1'b0}};
      rd_ptr_reg <= {`FPF_PTR_W{1'b0}};
      seen1_reg <= {`FPF_PTR_W{1'b0}};
      seen2_reg <= {`FPF_PTR_W{1'b0}};
      head_data_reg <= {`FPF_DATA_W{1'b0}};
      head_valid_reg <= 1'b0;
      has_space_reg <= 1'b1;
      near_empty_reg <= 1'b0;
      near_full_reg <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(`FPF_PTR_W-1){1'b0}}, 1'b1};
      end
      if (pop_tick) begin
        seen1_reg <= wr_ptr_reg;
        seen2_reg <= seen1_reg;
      end
      if (load) begin
        head_data_reg <= mem[rd_ptr_reg[`FPF_ADDR_W-1:0]];
        rd_ptr_reg <= rd_ptr_reg + {{(`FPF_PTR_W-1){1'b0}}, 1'b1};
        head_valid_reg <= 1'b1;
      end else if (pop_tick & pop_take) begin
        head_valid_reg <= 1'b0;
      end
      // word in the output register no longer counts as stored
      has_space_reg <= (stored_next != `FPF_DEPTH);
      near_empty_reg <= (stored_next > {1'b0, near_empty_off});
      near_full_reg <= (free_next > {1'b0, near_full_off});
    end
  end

endmodule

// ### rtl/fpf_regs.vh
`ifndef FPF_REGS_VH
`define FPF_REGS_VH

// queue geometry
`define FPF_DATA_W 36
`define FPF_PTR_W 10
`define FPF_ADDR_W 9
`define FPF_DEPTH 10'h200
`define FPF_OFF_W 9

// offset field on the data bus
`define FPF_OFF_LSB 0
`define FPF_OFF_MSB 8

// offset mode codes {offset_select_1, offset_select_0}
`define FPF_MODE_PROG 2'h0
`define FPF_MODE_PRESET_A 2'h1
`define FPF_MODE_PRESET_B 2'h2
`define FPF_MODE_PRESET_C 2'h3

// built-in offset presets
`define FPF_PRESET_A 9'h008
`define FPF_PRESET_B 9'h010
`define FPF_PRESET_C 9'h040
`define FPF_OFF_RESET 9'h008

// offset programming sequence
`define FPF_PROG_CNT_W 2
`define FPF_PROG_NE_A 2'h0
`define FPF_PROG_NE_B 2'h1
`define FPF_PROG_NF_A 2'h2
`define FPF_PROG_NF_B 2'h3

`endif

// ### tb/fpf_port_chk.sv
`include "fpf_regs.vh"
module fpf_port_chk (
  input wire sys_clk,
  input wire rst,
  input wire offset_select_0,
  input wire offset_select_1,
  input wire port_a_select_n,
  input wire port_a_direction,
  input wire [`FPF_DATA_W-1:0] port_a_data_out,
  input wire port_a_data_oe_reg,
  input wire out_valid_port_a,
  input wire near_full_port_b,
  input wire prog_active_reg,
  input wire user_rd_en,
  input wire [`FPF_DATA_W-1:0] user_rd_data,
  input wire user_rd_valid,
  input wire user_wr_valid,
  input wire user_wr_space,
  input wire near_empty_port_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    !user_rd_valid && !out_valid_port_a && near_full_port_b) else $error("bad reset state");
  prog_mode_a: assert property ($fell(rst) |->
    prog_active_reg == !(offset_select_0 || offset_select_1)) else $error("bad mode");
  prog_no_word_a: assert property (prog_active_reg |->
    !user_rd_valid && !near_empty_port_b) else $error("word during prog");
  oe_read_a: assert property ((!port_a_select_n && !port_a_direction)[*4] |->
    port_a_data_oe_reg) else $error("oe missing");
  oe_idle_a: assert property (port_a_select_n[*4] |-> !port_a_data_oe_reg)
    else $error("oe stray");
  fall_thru_a: assert property (
    user_wr_valid && user_wr_space && !out_valid_port_a |-> ##[1:32] out_valid_port_a)
    else $error("no fallthrough");
  user_hold_a: assert property (user_rd_valid && !user_rd_en |=>
    user_rd_valid && $stable(user_rd_data)) else $error("head moved");
  port_hold_a: assert property ((out_valid_port_a && port_a_select_n)[*5] |=>
    out_valid_port_a && $stable(port_a_data_out)) else $error("port head moved");
endmodule

// ### tb/fpf_port_test.sv
`include "fpf_regs.vh"
module fpf_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic offset_select_0 = 1'b0;
  logic offset_select_1 = 1'b0;
  logic user_wr_valid = 1'b0;
  logic user_rd_en = 1'b0;
  logic [`FPF_DATA_W-1:0] user_wr_data = '0;
  logic [`FPF_DATA_W-1:0] q;
  wire [`FPF_DATA_W-1:0] port_a_data_in, port_a_data_out, user_rd_data;
  wire port_a_clock, port_a_select_n, port_a_enable, port_a_direction;
  wire port_a_data_oe_reg, out_valid_port_a, in_space_port_a, near_empty_port_a;
  wire near_full_port_a, prog_active_reg, user_wr_space, user_rd_valid;
  wire near_empty_port_b, near_full_port_b, proc_irq_packet, proc_irq_space;
  int error_cnt = 0;
  int n_tests = 0;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  fpf_port u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .offset_select_0(offset_select_0),
    .offset_select_1(offset_select_1),
    .port_a_clock(port_a_clock),
    .port_a_select_n(port_a_select_n),
    .port_a_enable(port_a_enable),
    .port_a_direction(port_a_direction),
    .port_a_data_in(port_a_data_in),
    .port_a_data_out(port_a_data_out),
    .port_a_data_oe_reg(port_a_data_oe_reg),
    .out_valid_port_a(out_valid_port_a),
    .in_space_port_a(in_space_port_a),
    .near_empty_port_a(near_empty_port_a),
    .near_full_port_a(near_full_port_a),
    .prog_active_reg(prog_active_reg),
    .user_wr_valid(user_wr_valid),
    .user_wr_data(user_wr_data),
    .user_wr_space(user_wr_space),
    .user_rd_en(user_rd_en),
    .user_rd_data(user_rd_data),
    .user_rd_valid(user_rd_valid),
    .near_empty_port_b(near_empty_port_b),
    .near_full_port_b(near_full_port_b)
  );
  fpf_proc_model u_proc (
    .sys_clk(sys_clk),
    .near_empty_port_a(near_empty_port_a),
    .near_full_port_a(near_full_port_a),
    .port_a_data_out(port_a_data_out),
    .port_a_clock(port_a_clock),
    .port_a_select_n(port_a_select_n),
    .port_a_enable(port_a_enable),
    .port_a_direction(port_a_direction),
    .port_a_data_in(port_a_data_in),
    .proc_irq_packet(proc_irq_packet),
    .proc_irq_space(proc_irq_space)
  );
  task automatic chk(input string nm, input logic [`FPF_DATA_W-1:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset(input logic s1, s0);
    @(posedge sys_clk);
    offset_select_1 <= s1;
    offset_select_0 <= s0;
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("prog_active", !(s1 | s0), prog_active_reg);
  endtask
  task automatic wr(input logic [`FPF_DATA_W-1:0] d);
    u_proc.xfer(1'b1, d, q);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_prog;
    wr({27'h7ffffff, 9'h002});
    wr({27'h7ffffff, 9'h001});
    wr({27'h2aaaaaa, 9'h1fc});
    chk("prog_mid", 1'b1, prog_active_reg);
    wr({27'h7ffffff, 9'h100});
    chk("prog_end", 1'b0, prog_active_reg);
    chk("no_word", 1'b0, user_rd_valid);
    $display("t_prog done");
  endtask
  task automatic t_fwd;
    chk("in_space", 1'b1, in_space_port_a);
    chk("nf_a_pre", 1'b1, near_full_port_a);
    for (int i = 0; i < 5; i++) begin
      wr(36'h9a0000000 + i);
      chk("fall_thru", 36'h9a0000000, user_rd_data);
      chk("ne_b", i >= 2, near_empty_port_b);
      chk("nf_a", i < 4, near_full_port_a);
    end
    chk("irq_space", 1'b1, proc_irq_space);
    for (int i = 0; i < 5; i++) begin
      chk("fwd_order", 36'h9a0000000 + i, user_rd_data);
      user_rd_en <= 1'b1;
      @(posedge sys_clk);
      user_rd_en <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    chk("fwd_empty", 1'b0, user_rd_valid);
    $display("t_fwd done");
  endtask
  task automatic push_ret(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      user_wr_valid <= 1'b1;
      user_wr_data <= 36'h5b0000000 + i;
    end
    @(posedge sys_clk);
    user_wr_valid <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic t_ret;
    push_ret(4);
    chk("ret_valid", 1'b1, out_valid_port_a);
    chk("ne_a_hi", 1'b1, near_empty_port_a);
    chk("irq_packet", 1'b0, proc_irq_packet);
    for (int i = 0; i < 4; i++) begin
      u_proc.xfer(1'b0, '0, q);
      chk("ret_order", 36'h5b0000000 + i, q);
      repeat (4) @(posedge sys_clk);
      if (i == 0)
        chk("ne_a_lo", 1'b0, near_empty_port_a);
    end
    chk("ret_empty", 1'b0, out_valid_port_a);
    chk("irq_idle", 1'b1, proc_irq_packet);
    $display("t_ret done");
  endtask
  task automatic t_preset;
    int off;
    for (int m = 1; m < 4; m++) begin
      do_reset(m[1], m[0]);
      off = (m == 1) ? `FPF_PRESET_A : (m == 2) ? `FPF_PRESET_B : `FPF_PRESET_C;
      wr(36'h0c0000001 + m);
      chk("preset_word", 36'h0c0000001 + m, user_rd_data);
      push_ret(off + 1);
      chk("pre_ne_lo", 1'b0, near_empty_port_a);
      push_ret(1);
      chk("pre_ne_hi", 1'b1, near_empty_port_a);
      push_ret(`FPF_DEPTH - 2 * off - 2);
      chk("pre_nf_hi", 1'b1, near_full_port_b);
      push_ret(1);
      chk("pre_nf_lo", 1'b0, near_full_port_b);
      push_ret(off);
      chk("ret_full", 1'b0, user_wr_space);
    end
    $display("t_preset done");
  endtask
  initial begin
    do_reset(1'b0, 1'b0);
    t_prog;
    t_fwd;
    t_ret;
    t_preset;
    test_done;
  end
  initial begin
    #1000000;
    error_cnt++;
    test_done;
  end
endmodule
bind fpf_port fpf_port_chk u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .offset_select_0(offset_select_0),
  .offset_select_1(offset_select_1),
  .port_a_select_n(port_a_select_n),
  .port_a_direction(port_a_direction),
  .port_a_data_out(port_a_data_out),
  .port_a_data_oe_reg(port_a_data_oe_reg),
  .out_valid_port_a(out_valid_port_a),
  .near_full_port_b(near_full_port_b),
  .prog_active_reg(prog_active_reg),
  .user_rd_en(user_rd_en),
  .user_rd_data(user_rd_data),
  .user_rd_valid(user_rd_valid),
  .user_wr_valid(user_wr_valid),
  .user_wr_space(user_wr_space),
  .near_empty_port_b(near_empty_port_b)
);

// ### tb/fpf_proc_model.sv
`include "fpf_regs.vh"
module fpf_proc_model (
  input wire sys_clk,
  input wire near_empty_port_a,
  input wire near_full_port_a,
  input wire [`FPF_DATA_W-1:0] port_a_data_out,
  output logic port_a_clock,
  output logic port_a_select_n,
  output logic port_a_enable,
  output logic port_a_direction,
  output logic [`FPF_DATA_W-1:0] port_a_data_in,
  output wire proc_irq_packet,
  output wire proc_irq_space
);
  timeunit 1ns;
  timeprecision 1ns;
  assign proc_irq_packet = !near_empty_port_a;
  assign proc_irq_space = !near_full_port_a;
  initial begin
    port_a_clock = 1'b0;
    port_a_select_n = 1'b1;
    port_a_enable = 1'b0;
    port_a_direction = 1'b0;
    port_a_data_in = '0;
    #7;
    forever #80 port_a_clock = ~port_a_clock;
  end
  // bus moves after the falling edge, held across the rising edge
  task automatic xfer(input logic dir, input logic [`FPF_DATA_W-1:0] d,
      output logic [`FPF_DATA_W-1:0] q);
    @(negedge port_a_clock);
    @(posedge sys_clk);
    port_a_select_n <= 1'b0;
    port_a_direction <= dir;
    port_a_data_in <= d;
    @(posedge sys_clk);
    port_a_enable <= 1'b1;
    @(posedge port_a_clock);
    q = port_a_data_out;
    @(negedge port_a_clock);
    @(posedge sys_clk);
    port_a_select_n <= 1'b1;
    port_a_data_in <= ~d;
    @(posedge sys_clk);
    port_a_enable <= 1'b0;
  endtask
endmodule
